/* rtl/bsi_board_status.sv */
// Board control/status register, timeout timers and interrupt level encoder.
// Assumes processor bus strobes are synchronous to clk_sys; pins from peripherals are not.
`timescale 1ns/1ps

// Overview of operation
// - Periodic timer counts 100 kHz ticks, reloads, sets bit 6, raises level 15.
// - Bit 6 and its level 15 request stay until the 0x42010 write.
// - Watchdog expiry lights diagnostic indicator, raises level 15, sets bit 15.
// - Bus timer counts 2 MHz ticks, held reloaded while arbiter acknowledge inactive.
// - Bus timer expiry sends fault, lights indicator, raises level 15, sets bit 15.
// - Bit 15 cleared by 0x44000 write; software tells sources apart elsewhere.
// - Sixteen-bit status readable whole, captured at read start and held.
// - System reset changes only bits 13, 11 and 7.
// - Each write touches one bit chosen by address; data ignored.
// - Bits 3 to 0 mirror live peripheral lines and cannot be written.
// - Parity sets bit 14, alignment sets bit 12; writes clear them.
// - Write sets bit 13 reset request; system reset clears it.
// - Bit 11 drives indicator; set and clear writes; system reset sets it.
// - Bits 7, 8 and 10 have set and clear addresses; reset sets bit 7.
// - Bit 5 is level 8 software request with set and clear addresses.
// - Bit 4 is level 9 software request with set and clear addresses.
// - Eight sources priority-encoded to a 3-bit code, levels 15 down to 8.
// - Card acknowledge first requests bypass, proceeds only after bypass acknowledge.
// - Acknowledge address bit 2 low with bit 3 or 4 high means off-board.
// - Other acknowledges return level as vector and assert wait select.
// - Level 11 shared by disks; bit 2 high means floppy source.
// - Level 15 merges system errors and periodic timer.
// - Level 13 is serial plus transfer done; levels 9, 8 software bits.
module bsi_board_status #(
   parameter logic [bsi_pkg::CNT_W-1:0] PERIODIC_RELOAD = 16'h03E8,
   parameter logic [bsi_pkg::CNT_W-1:0] BUS_RELOAD = 16'h0014
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Processor bus, synchronous
   input wire logic [31:0] cpu_addr,
   input wire logic cpu_wr_strobe,
   input wire logic cpu_rd_start,
   input wire logic cpu_iack_start,
   input wire logic cpu_iack_active,
   output logic [31:0] cpu_rd_data,
   output logic [7:0] vector_data,
   output logic vector_oe,
   output logic onboard_wait_select_n,
   // Timer controls
   input wire logic [bsi_pkg::CNT_W-1:0] watchdog_reload_value,
   input wire logic watchdog_reload,
   // Peripheral lines, asynchronous
   input wire logic sys_reset,
   input wire logic uart_irq,
   input wire logic floppy_irq,
   input wire logic hard_disk_irq,
   input wire logic dma_irq,
   input wire logic board_fail,
   input wire logic parity_error,
   input wire logic alignment_fault,
   input wire logic [2:0] card_irq_lines_n,
   input wire logic arb_ack,
   input wire logic bypass_ack,
   // Arbiter and system outputs
   output logic bus_timeout_fault,
   output logic bypass_request,
   output logic [2:0] card_iack,
   output logic [2:0] irq_code,
   output logic irq_pending,
   output logic diag_indicator,
   output logic floppy_motor,
   output logic reset_request
);
   import bsi_pkg::*;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   localparam int NSYNC = 13;
   logic [NSYNC-1:0] pin_raw, sync1_r, sync2_r;
   assign pin_raw = {bypass_ack, arb_ack, ~card_irq_lines_n, alignment_fault, parity_error,
                     board_fail, dma_irq, hard_disk_irq, floppy_irq, uart_irq, sys_reset};
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= pin_raw;
         sync2_r <= sync1_r;
      end
   end
   logic sysrst_s, uart_s, floppy_s, hdisk_s, dma_s, fail_s, parity_s, align_s, arb_s, byp_s;
   logic [2:0] card_s;
   assign {byp_s, arb_s, card_s, align_s, parity_s, fail_s, dma_s, hdisk_s, floppy_s, uart_s,
           sysrst_s} = sync2_r;

   // ****************************************
   // Time bases and timers
   // ****************************************
   logic tick_slow, tick_fast, periodic_zero, watchdog_zero, bus_zero;
   logic [CNT_W-1:0] bus_count;
   // Dividers are down counters too; their expiry pulse is the time-base enable
   bsi_down_counter #(.WIDTH(DIV_W)) u_div_slow (.clk_sys(clk_sys), .resetn(resetn), .tick(1'b1), .hold(1'b0),
      .reload(1'b0), .reload_value(DIV_W'(PERIODIC_DIV)), .count(), .expired(tick_slow));
   bsi_down_counter #(.WIDTH(DIV_W)) u_div_fast (.clk_sys(clk_sys), .resetn(resetn), .tick(1'b1), .hold(1'b0),
      .reload(1'b0), .reload_value(DIV_W'(BUS_DIV)), .count(), .expired(tick_fast));
   // Both 100 kHz bases share one divider since their rates match
   bsi_down_counter #(.WIDTH(CNT_W)) u_periodic (.clk_sys(clk_sys), .resetn(resetn),
      .tick(tick_slow), .hold(1'b0), .reload(1'b0), .reload_value(PERIODIC_RELOAD),
      .count(), .expired(periodic_zero));
   bsi_down_counter #(.WIDTH(CNT_W)) u_watchdog (.clk_sys(clk_sys), .resetn(resetn),
      .tick(tick_slow), .hold(1'b0), .reload(watchdog_reload),
      .reload_value(watchdog_reload_value), .count(), .expired(watchdog_zero));
   bsi_down_counter #(.WIDTH(CNT_W)) u_bus (.clk_sys(clk_sys), .resetn(resetn),
      .tick(tick_fast), .hold(!arb_s), .reload(1'b0), .reload_value(BUS_RELOAD),
      .count(bus_count), .expired(bus_zero));

   // ****************************************
   // Control and status register
   // ****************************************
   logic [15:0] csr_r, csr_nxt;
   logic [31:0] rd_data_r, rd_data_nxt;
   logic fault_r, fault_nxt, parity_d_r, align_d_r;
   always_comb begin
      csr_nxt = csr_r;
      // Clears first so that hardware sets in the same cycle win
      if (cpu_wr_strobe) begin
         if (cpu_addr == ADDR_CLR_PERIODIC) csr_nxt[B_PERIODIC] = 1'b0;
         else if (cpu_addr == ADDR_CLR_TIMEOUT) csr_nxt[B_TIMEOUT] = 1'b0;
         else if (cpu_addr == ADDR_CLR_PARITY) csr_nxt[B_PARITY] = 1'b0;
         else if (cpu_addr == ADDR_SET_RESET_REQ) csr_nxt[B_RESET_REQ] = 1'b1;
         else if (cpu_addr == ADDR_CLR_ALIGN) csr_nxt[B_ALIGN] = 1'b0;
         else if (cpu_addr == ADDR_SET_DIAG) csr_nxt[B_DIAG] = 1'b1;
         else if (cpu_addr == ADDR_CLR_DIAG) csr_nxt[B_DIAG] = 1'b0;
         else if (cpu_addr == ADDR_SET_MOTOR) csr_nxt[B_MOTOR] = 1'b1;
         else if (cpu_addr == ADDR_CLR_MOTOR) csr_nxt[B_MOTOR] = 1'b0;
         else if (cpu_addr == ADDR_SET_INH_TIMERS) csr_nxt[B_INH_TIMERS] = 1'b1;
         else if (cpu_addr == ADDR_CLR_INH_TIMERS) csr_nxt[B_INH_TIMERS] = 1'b0;
         else if (cpu_addr == ADDR_SET_INH_FAULTS) csr_nxt[B_INH_FAULTS] = 1'b1;
         else if (cpu_addr == ADDR_CLR_INH_FAULTS) csr_nxt[B_INH_FAULTS] = 1'b0;
         else if (cpu_addr == ADDR_SET_SWIRQ9) csr_nxt[B_SWIRQ9] = 1'b1;
         else if (cpu_addr == ADDR_CLR_SWIRQ9) csr_nxt[B_SWIRQ9] = 1'b0;
         else if (cpu_addr == ADDR_SET_SWIRQ8) csr_nxt[B_SWIRQ8] = 1'b1;
         else if (cpu_addr == ADDR_CLR_SWIRQ8) csr_nxt[B_SWIRQ8] = 1'b0;
      end
      // Only these three bits follow the system reset line
      if (sysrst_s) begin
         csr_nxt[B_RESET_REQ] = 1'b0;
         csr_nxt[B_DIAG] = 1'b1;
         csr_nxt[B_INH_FAULTS] = 1'b1;
      end
      if (periodic_zero) csr_nxt[B_PERIODIC] = 1'b1;
      if (watchdog_zero || bus_zero) begin
         csr_nxt[B_TIMEOUT] = 1'b1;
         csr_nxt[B_DIAG] = 1'b1;
      end
      // Edge capture so a clear while the cause persists is not undone at once
      if (parity_s && !parity_d_r) csr_nxt[B_PARITY] = 1'b1;
      if (align_s && !align_d_r) csr_nxt[B_ALIGN] = 1'b1;
      csr_nxt[3:0] = {uart_s, floppy_s, dma_s, fail_s};
      csr_nxt[9] = 1'b0;
      fault_nxt = bus_zero;
      rd_data_nxt = rd_data_r;
      if (cpu_rd_start) rd_data_nxt = {16'h0000, csr_r};
   end
   // Power-up value only; the documented system reset never clears the whole register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         csr_r <= CSR_POWERUP;
         rd_data_r <= '0;
         fault_r <= 1'b0;
         parity_d_r <= 1'b0;
         align_d_r <= 1'b0;
      end else begin
         csr_r <= csr_nxt;
         rd_data_r <= rd_data_nxt;
         fault_r <= fault_nxt;
         parity_d_r <= parity_s;
         align_d_r <= align_s;
      end
   end

   // ****************************************
   // Interrupt level encoder
   // ****************************************
   logic [7:0] src;
   logic [3:0] lvl_nxt, lvl_r;
   logic pend_r;
   always_comb begin
      src[7] = (!csr_r[B_INH_FAULTS] && (csr_r[B_PARITY] || csr_r[B_ALIGN] || fail_s))
               || csr_r[B_TIMEOUT] || csr_r[B_PERIODIC];
      src[6] = card_s[2];
      src[5] = uart_s || dma_s;
      src[4] = card_s[1];
      src[3] = floppy_s || hdisk_s;
      src[2] = card_s[0];
      src[1] = csr_r[B_SWIRQ9];
      src[0] = csr_r[B_SWIRQ8];
      lvl_nxt = LVL_NONE;
      for (int i = 0; i < 8; i++) begin
         if (src[i]) lvl_nxt = LVL_BASE + 4'(i);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         lvl_r <= LVL_NONE;
         pend_r <= 1'b0;
      end else begin
         lvl_r <= lvl_nxt;
         pend_r <= |src;
      end
   end

   // ****************************************
   // Interrupt acknowledge sequencer
   // ****************************************
   bsi_ack_e ack_r, ack_nxt;
   logic [3:0] ack_lvl_r, ack_lvl_nxt;
   logic offboard, byp_req_r, byp_req_nxt, wsel_n_r, wsel_n_nxt, voe_r, voe_nxt;
   logic [2:0] card_ack_r, card_ack_nxt;
   assign offboard = !cpu_addr[2] && (cpu_addr[3] || cpu_addr[4]);
   always_comb begin
      ack_nxt = ack_r;
      ack_lvl_nxt = ack_lvl_r;
      byp_req_nxt = byp_req_r;
      wsel_n_nxt = wsel_n_r;
      voe_nxt = voe_r;
      card_ack_nxt = card_ack_r;
      case (ack_r)
         ACK_IDLE: begin
            if (cpu_iack_start) begin
               ack_lvl_nxt = cpu_addr[5:2];
               if (offboard) begin
                  ack_nxt = ACK_BYPASS;
                  byp_req_nxt = 1'b1;
               end else begin
                  ack_nxt = ACK_ONBOARD;
                  wsel_n_nxt = 1'b0;
                  voe_nxt = 1'b1;
               end
            end
         end
         ACK_BYPASS: begin
            if (!cpu_iack_active) begin
               ack_nxt = ACK_IDLE;
               byp_req_nxt = 1'b0;
            end else if (byp_s) begin
               ack_nxt = ACK_CARD;
               card_ack_nxt = {ack_lvl_r == LVL_CARD_HI, ack_lvl_r == LVL_CARD_MID,
                               ack_lvl_r == LVL_CARD_LO};
            end
         end
         ACK_CARD, ACK_ONBOARD: begin
            if (!cpu_iack_active) begin
               ack_nxt = ACK_IDLE;
               byp_req_nxt = 1'b0;
               wsel_n_nxt = 1'b1;
               voe_nxt = 1'b0;
               card_ack_nxt = '0;
            end
         end
         default: ack_nxt = ACK_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ack_r <= ACK_IDLE;
         ack_lvl_r <= '0;
         byp_req_r <= 1'b0;
         wsel_n_r <= 1'b1;
         voe_r <= 1'b0;
         card_ack_r <= '0;
      end else begin
         ack_r <= ack_nxt;
         ack_lvl_r <= ack_lvl_nxt;
         byp_req_r <= byp_req_nxt;
         wsel_n_r <= wsel_n_nxt;
         voe_r <= voe_nxt;
         card_ack_r <= card_ack_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign cpu_rd_data = rd_data_r;
   assign vector_data = {4'h0, ack_lvl_r};
   assign vector_oe = voe_r;
   assign onboard_wait_select_n = wsel_n_r;
   assign bus_timeout_fault = fault_r;
   assign bypass_request = byp_req_r;
   assign card_iack = card_ack_r;
   assign irq_code = lvl_r[2:0];
   assign irq_pending = pend_r;
   assign diag_indicator = csr_r[B_DIAG];
   assign floppy_motor = csr_r[B_MOTOR];
   assign reset_request = csr_r[B_RESET_REQ];

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_periodic_sets_bit: assert property (periodic_zero |=> csr_r[B_PERIODIC])
      else $error("periodic expiry did not set bit 6");
   a_periodic_holds_top: assert property (csr_r[B_PERIODIC] |=> irq_pending && irq_code == 3'h7)
      else $error("bit 6 not holding level 15");
   a_bus_timer_held: assert property (!arb_s |=> bus_count == BUS_RELOAD)
      else $error("bus timer ran without arbiter acknowledge");
   a_bus_fault_effects: assert property (bus_zero |=> bus_timeout_fault && csr_r[B_TIMEOUT] && diag_indicator)
      else $error("bus timeout effects missing");
   a_watchdog_effects: assert property (watchdog_zero |=> csr_r[B_TIMEOUT] && diag_indicator)
      else $error("watchdog expiry effects missing");
   a_timeout_clear: assert property (cpu_wr_strobe && cpu_addr == ADDR_CLR_TIMEOUT && !bus_zero
      && !watchdog_zero |=> !csr_r[B_TIMEOUT])
      else $error("bit 15 not cleared by write");
   a_read_data_stable: assert property (!cpu_rd_start |=> $stable(cpu_rd_data))
      else $error("read data changed without read start");
   a_live_bits_follow: assert property (##1 csr_r[3:0] == $past({uart_s, floppy_s, dma_s, fail_s}))
      else $error("live status bits not mirrored");
   a_reset_req_set: assert property (cpu_wr_strobe && cpu_addr == ADDR_SET_RESET_REQ && !sysrst_s
      |=> reset_request)
      else $error("reset request not set");
   a_offboard_bypass: assert property (ack_r == ACK_IDLE && cpu_iack_start && offboard
      |=> bypass_request && vector_oe == 1'b0)
      else $error("off-board acknowledge did not request bypass");
   a_card_after_bypass: assert property ($rose(|card_iack) |-> bypass_request && $past(byp_s))
      else $error("card acknowledged before bypass granted");
   a_onboard_vector: assert property (ack_r == ACK_IDLE && cpu_iack_start && !offboard
      |=> !onboard_wait_select_n && vector_data[3:0] == $past(cpu_addr[5:2]))
      else $error("on-board vector or wait select wrong");
   c_periodic_event: cover property (periodic_zero ##1 csr_r[B_PERIODIC]);
   c_onboard_ack: cover property (ack_r == ACK_ONBOARD ##1 ack_r == ACK_IDLE);
   c_card_ack: cover property (ack_r == ACK_BYPASS ##1 ack_r == ACK_CARD);
   c_bus_timeout: cover property (bus_zero);
endmodule // bsi_board_status

/* rtl/bsi_pkg.sv */
// Package for the board status and interrupt logic.
// Assumes one 100 MHz system clock; processor bus strobes arrive on that clock.
package bsi_pkg;

   // ****************************************
   // Clock and time bases
   // ****************************************
   localparam int CLK_SYS_HZ = 100_000_000;
   localparam int PERIODIC_BASE_HZ = 100_000;
   localparam int WATCHDOG_BASE_HZ = 100_000;
   localparam int BUS_BASE_HZ = 2_000_000;
   localparam int PERIODIC_DIV = CLK_SYS_HZ / PERIODIC_BASE_HZ;
   localparam int WATCHDOG_DIV = CLK_SYS_HZ / WATCHDOG_BASE_HZ;
   localparam int BUS_DIV = CLK_SYS_HZ / BUS_BASE_HZ;
   localparam int DIV_W = 10;
   localparam int CNT_W = 16;

   // ****************************************
   // Status register write addresses
   // ****************************************
   localparam logic [31:0] ADDR_CLR_PERIODIC = 32'h0004_2010;
   localparam logic [31:0] ADDR_CLR_TIMEOUT = 32'h0004_4000;
   localparam logic [31:0] ADDR_CLR_PARITY = 32'h0004_4004;
   localparam logic [31:0] ADDR_SET_RESET_REQ = 32'h0004_4008;
   localparam logic [31:0] ADDR_CLR_ALIGN = 32'h0004_400C;
   localparam logic [31:0] ADDR_SET_DIAG = 32'h0004_4010;
   localparam logic [31:0] ADDR_CLR_DIAG = 32'h0004_4014;
   localparam logic [31:0] ADDR_SET_MOTOR = 32'h0004_4018;
   localparam logic [31:0] ADDR_CLR_MOTOR = 32'h0004_401C;
   localparam logic [31:0] ADDR_SET_INH_TIMERS = 32'h0004_4020;
   localparam logic [31:0] ADDR_CLR_INH_TIMERS = 32'h0004_4024;
   localparam logic [31:0] ADDR_SET_INH_FAULTS = 32'h0004_4028;
   localparam logic [31:0] ADDR_CLR_INH_FAULTS = 32'h0004_402C;
   localparam logic [31:0] ADDR_SET_SWIRQ9 = 32'h0004_4030;
   localparam logic [31:0] ADDR_CLR_SWIRQ9 = 32'h0004_4034;
   localparam logic [31:0] ADDR_SET_SWIRQ8 = 32'h0004_4038;
   localparam logic [31:0] ADDR_CLR_SWIRQ8 = 32'h0004_403C;

   // ****************************************
   // Status register bit positions
   // ****************************************
   localparam int B_BOARD_FAIL = 0;
   localparam int B_DMA = 1;
   localparam int B_FLOPPY = 2;
   localparam int B_UART = 3;
   localparam int B_SWIRQ9 = 4;
   localparam int B_SWIRQ8 = 5;
   localparam int B_PERIODIC = 6;
   localparam int B_INH_FAULTS = 7;
   localparam int B_INH_TIMERS = 8;
   localparam int B_MOTOR = 10;
   localparam int B_DIAG = 11;
   localparam int B_ALIGN = 12;
   localparam int B_RESET_REQ = 13;
   localparam int B_PARITY = 14;
   localparam int B_TIMEOUT = 15;
   localparam logic [15:0] CSR_POWERUP = 16'h0880;

   // ****************************************
   // Interrupt levels and acknowledge
   // ****************************************
   localparam logic [3:0] LVL_NONE = 4'h0;
   localparam logic [3:0] LVL_BASE = 4'h8;
   localparam logic [3:0] LVL_CARD_HI = 4'hE;
   localparam logic [3:0] LVL_CARD_MID = 4'hC;
   localparam logic [3:0] LVL_CARD_LO = 4'hA;
   typedef enum logic [1:0] {ACK_IDLE, ACK_BYPASS, ACK_CARD, ACK_ONBOARD} bsi_ack_e;

endpackage

/* rtl/bsi_down_counter.sv */
// Reloading down counter stepped by a time-base enable pulse.
// Assumes tick is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps
module bsi_down_counter #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Control
   input wire logic tick,
   input wire logic hold,
   input wire logic reload,
   input wire logic [WIDTH-1:0] reload_value,
   // Status
   output logic [WIDTH-1:0] count,
   output logic expired
);
   logic [WIDTH-1:0] count_r, count_nxt;
   logic expired_r, expired_nxt;

   // Hold or reload wins over counting; a tick at one or zero reloads and flags expiry
   always_comb begin
      count_nxt = count_r;
      expired_nxt = 1'b0;
      if (hold || reload) begin
         count_nxt = reload_value;
      end else if (tick) begin
         if (count_r <= WIDTH'(1)) begin
            count_nxt = reload_value;
            expired_nxt = 1'b1;
         end else begin
            count_nxt = count_r - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         count_r <= '0;
         expired_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         expired_r <= expired_nxt;
      end
   end

   assign count = count_r;
   assign expired = expired_r;
endmodule // bsi_down_counter

/* dv/bsi_bus_partner.sv */
// Model of the bus arbiter and bypass sequencer facing the board status logic.
// Assumes the same clk_sys as the design; all signals are levels.
`timescale 1ns/1ps
module bsi_bus_partner #(
   parameter int ACK_DELAY = 5
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Commands and requests
   input wire logic hold_arb,
   input wire logic bypass_request,
   // Answers
   output logic arb_ack,
   output logic bypass_ack
);
   // ****************************************
   // Arbiter answers
   // ****************************************
   int wait_r;
   // Acknowledge stays up only while the bench stalls an access
   assign arb_ack = hold_arb;
   // Grant is slow on purpose so the design must wait for it
   always_ff @(posedge clk_sys) begin
      if (!resetn || !bypass_request) begin
         wait_r <= 0;
         bypass_ack <= 1'b0;
      end else begin
         wait_r <= wait_r + 1;
         bypass_ack <= (wait_r >= ACK_DELAY);
      end
   end
endmodule // bsi_bus_partner

/* dv/testbench.sv */
// Self-checking bench for the board status and interrupt logic.
// Assumes short timer reloads and the bus partner answering bypass requests.
`timescale 1ns/1ps
module testbench;
   import bsi_pkg::*;
   // ****************************************
   // Stimulus and checking
   // ****************************************
   logic clk_sys = 0, resetn = 0, wr = 0, rd = 0, iks = 0, ika = 0, wdr = 0, srst = 0, hold = 0, hd = 0;
   logic par = 0, aln = 0, rd_d = 0, voe, wait_n, tof, byr, byk, arb, pend, diag, mot, rreq;
   logic [31:0] addr = '0, rdat;
   logic [3:0] pin = '0;
   logic [2:0] card_n = 3'h7, ciack, code;
   logic [15:0] exp_csr = CSR_POWERUP, wdv = 16'hFFFF;
   logic [7:0] vdat;
   logic [31:0] exp_q[$];
   int error_cnt = 0, checks = 0;
   int tb_bit[16] = '{15, 14, 13, 12, 11, 11, 10, 10, 8, 8, 7, 7, 4, 4, 5, 5};

   bsi_board_status #(.PERIODIC_RELOAD(16'h0003), .BUS_RELOAD(16'h0002)) i_bsi_board_status (
      .clk_sys, .resetn, .cpu_addr(addr), .cpu_wr_strobe(wr), .cpu_rd_start(rd), .cpu_iack_start(iks),
      .cpu_iack_active(ika), .cpu_rd_data(rdat), .vector_data(vdat), .vector_oe(voe),
      .onboard_wait_select_n(wait_n), .watchdog_reload_value(wdv), .watchdog_reload(wdr),
      .sys_reset(srst), .uart_irq(pin[3]), .floppy_irq(pin[2]), .hard_disk_irq(hd), .dma_irq(pin[1]),
      .board_fail(pin[0]), .parity_error(par), .alignment_fault(aln), .card_irq_lines_n(card_n),
      .arb_ack(arb), .bypass_ack(byk), .bus_timeout_fault(tof), .bypass_request(byr), .card_iack(ciack),
      .irq_code(code), .irq_pending(pend), .diag_indicator(diag), .floppy_motor(mot), .reset_request(rreq));
   bsi_bus_partner i_bsi_bus_partner (.clk_sys, .resetn, .hold_arb(hold), .bypass_request(byr),
      .arb_ack(arb), .bypass_ack(byk));

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic wr_a(input logic [31:0] a);
      addr <= a;
      wr <= 1'b1;
      cyc(1);
      wr <= 1'b0;
      cyc(1);
   endtask

   // Upper half of a queue entry is the mask of bits worth comparing
   task automatic rd_x(input logic [15:0] m);
      exp_q.push_back({m, exp_csr});
      rd <= 1'b1;
      cyc(1);
      rd <= 1'b0;
      cyc(2);
   endtask

   task automatic enc(input logic [2:0] e);
      cyc(5);
      chk({pend, code}, {1'b1, e});
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Read data is taken one edge after the start pulse
   always @(posedge clk_sys) begin
      rd_d <= rd;
      if (rd_d) begin
         chk(rdat & {16'hFFFF, exp_q[0][31:16]}, {16'h0, exp_q[0][15:0] & exp_q[0][31:16]});
         void'(exp_q.pop_front());
      end
      if (tof === 1'b1 && !hold) chk(tof, 0);
   end

   initial begin
      #500us;
      error_cnt++;
      conclude();
   end

   initial begin
      void'($urandom(96));
      cyc(3);
      resetn <= 1'b1;
      wdr <= 1'b1;
      cyc(1);
      wdr <= 1'b0;
      cyc(2);
      rd_x(16'hFFBF);
      for (int i = 0; i < 4; i++) begin
         pin <= 4'($urandom);
         cyc(5);
         exp_csr[3:0] = pin;
         rd_x(16'hFFBF);
      end
      pin <= '0;
      cyc(5);
      exp_csr[3:0] = '0;
      $display("test reset and live bits done");
      for (int i = 0; i < 16; i++) begin
         wr_a(32'h0004_4000 + 32'(4 * i));
         exp_csr[tb_bit[i]] = (i == 2) || (i > 3 && i % 2 == 0);
         rd_x(16'hFFBF);
         chk({diag, mot, rreq}, {exp_csr[11], exp_csr[10], exp_csr[13]});
      end
      wr_a(32'h0004_4040);
      rd_x(16'hFFBF);
      wr_a(ADDR_SET_MOTOR);
      srst <= 1'b1;
      cyc(4);
      srst <= 1'b0;
      cyc(4);
      exp_csr = (exp_csr | 16'h0C80) & 16'hDFFF;
      rd_x(16'hFFBF);
      $display("test writes and system reset done");
      par <= 1'b1;
      aln <= 1'b1;
      cyc(4);
      par <= 1'b0;
      aln <= 1'b0;
      cyc(4);
      exp_csr[14] = 1'b1;
      exp_csr[12] = 1'b1;
      rd_x(16'hFFBF);
      wr_a(ADDR_CLR_PARITY);
      wr_a(ADDR_CLR_ALIGN);
      exp_csr[14] = 1'b0;
      exp_csr[12] = 1'b0;
      rd_x(16'hFFBF);
      hold <= 1'b1;
      for (int i = 0; i < 300 && tof !== 1'b1; i++) cyc(1);
      chk({tof, diag}, 2'b11);
      hold <= 1'b0;
      exp_csr[15] = 1'b1;
      rd_x(16'hFFBF);
      wr_a(ADDR_CLR_TIMEOUT);
      exp_csr[15] = 1'b0;
      rd_x(16'hFFBF);
      wr_a(ADDR_CLR_DIAG);
      wdv <= 16'h0002;
      wdr <= 1'b1;
      cyc(1);
      wdr <= 1'b0;
      for (int i = 0; i < 3000 && diag !== 1'b1; i++) cyc(1);
      chk(diag, 1);
      wdv <= 16'hFFFF;
      wdr <= 1'b1;
      cyc(1);
      wdr <= 1'b0;
      exp_csr[15] = 1'b1;
      exp_csr[11] = 1'b1;
      rd_x(16'hFFBF);
      wr_a(ADDR_CLR_TIMEOUT);
      exp_csr[15] = 1'b0;
      rd_x(16'hFFBF);
      $display("test faults done");
      wr_a(ADDR_CLR_PERIODIC);
      cyc(2);
      for (int i = 0; i < 4000 && !(pend === 1'b1 && code === 3'h7); i++) cyc(1);
      chk({pend, code}, 4'hF);
      cyc(20);
      exp_csr[6] = 1'b1;
      rd_x(16'hFFFF);
      wr_a(ADDR_CLR_PERIODIC);
      exp_csr[6] = 1'b0;
      rd_x(16'hFFFF);
      wr_a(ADDR_SET_SWIRQ8);
      enc(3'h0);
      wr_a(ADDR_SET_SWIRQ9);
      enc(3'h1);
      hd <= 1'b1;
      enc(3'h3);
      pin <= 4'h8;
      enc(3'h5);
      card_n <= 3'b011;
      enc(3'h6);
      $display("test timers and levels done");
      for (int l = 8; l < 16; l++) begin
         addr <= 32'(l << 2);
         iks <= 1'b1;
         ika <= 1'b1;
         cyc(1);
         iks <= 1'b0;
         cyc(1);
         if (l[0] == 1'b0 && (l[1] || l[2])) begin
            chk({byr, voe, ciack}, 5'b10000);
            for (int i = 0; i < 50 && ciack === 3'b000; i++) cyc(1);
            chk(ciack, 32'(1 << ((l - 10) / 2)));
         end else begin
            chk({byr, voe, wait_n, vdat}, {3'b010, 8'(l)});
         end
         ika <= 1'b0;
         cyc(3);
         chk({byr, voe, wait_n, ciack}, 6'b001000);
      end
      $display("test acknowledge done");
      conclude();
   end
endmodule // testbench
